// >>> src/fp_decide.sv
// combinational choice of how one instruction is dispatched
`timescale 1ns/1ns
module fp_decide
    import fp_dispatch_pkg::*;
(
    // flags and instruction class in, outcome out
    fp_decide_if.decide dec
);

    // sync instructions take priority over the plain floating-point path
    always_comb begin
        dec.outcome = OUT_NONE;
        if (dec.fpSyncInstr) begin
            if (dec.monitorCoprocessorFlag && dec.taskSwitchedFp) begin
                dec.outcome = OUT_FAULT;
            end else begin
                dec.outcome = OUT_SYNC_DONE;
            end
        end else if (dec.fpInstr) begin
            if (dec.fpSoftwareTrap && dec.noHelper) begin
                dec.outcome = OUT_HANG;
            end else if (dec.fpSoftwareTrap || dec.noFpHw) begin
                dec.outcome = OUT_FAULT;
            end else begin
                dec.outcome = OUT_EXEC;
            end
        end
    end

endmodule

// >>> src/fp_decide_if.sv
// carrier between the dispatch controller and its decision logic
`timescale 1ns/1ns
interface fp_decide_if;
    import fp_dispatch_pkg::*;

    logic     fpSoftwareTrap;
    logic     monitorCoprocessorFlag;
    logic     taskSwitchedFp;
    logic     fpInstr;
    logic     fpSyncInstr;
    logic     noFpHw;
    logic     noHelper;
    outcome_e outcome;

    modport ctrl (
        output fpSoftwareTrap,
        output monitorCoprocessorFlag,
        output taskSwitchedFp,
        output fpInstr,
        output fpSyncInstr,
        output noFpHw,
        output noHelper,
        input  outcome
    );

    modport decide (
        input  fpSoftwareTrap,
        input  monitorCoprocessorFlag,
        input  taskSwitchedFp,
        input  fpInstr,
        input  fpSyncInstr,
        input  noFpHw,
        input  noHelper,
        output outcome
    );
endinterface

// >>> src/fp_dispatch_control.sv
// floating-point dispatch control: control word, dispatch, error routing, events
`timescale 1ns/1ns
module fp_dispatch_control
    import fp_dispatch_pkg::*;
#(
    parameter bit FP_HW_PRESENT = 1'b1
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [DATA_W-1:0] regRdData,
    // instruction issue
    input  wire logic              instrValid,
    input  wire logic              instrIsFp,
    input  wire logic              instrIsFpSync,
    input  wire logic              taskSwitchEvent,
    input  wire logic              numericError,
    // platform presence levels
    input  wire logic              coprocPresent,
    input  wire logic              emulatorPresent,
    // dispatch results
    output logic                   fpuExecute,
    output logic                   fpuUnavailableFault,
    output logic                   syncComplete,
    output logic                   fpErrorFault,
    output logic                   extErrorRequest,
    output logic                   coreHung,
    output logic                   irq
);

    // whole module state
    typedef struct packed {
        run_e              state;
        logic              fpSoftwareTrap;
        logic              monitorCoprocessorFlag;
        logic              nativeFpError;
        logic              taskSwitchedFp;
        logic [EV_W-1:0]   status;
        logic [EV_W-1:0]   mask;
        logic [DATA_W-1:0] rdData;
        logic              exec;
        logic              fault;
        logic              syncDone;
        logic              fpErr;
        logic              extErr;
        logic              hung;
        logic              irq;
    } state_s;

    state_s st_reg;
    state_s st_next;

    logic            noFpHw;
    logic            accept;
    logic [EV_W-1:0] evSet;
    logic [CTRL_W-1:0] ctrlWord;

    fp_decide_if dif ();

    fp_decide u_decide (
        .dec (dif.decide)
    );

    // hardware absence combines the build option with the coprocessor strap
    assign noFpHw   = !FP_HW_PRESENT && !coprocPresent;
    assign accept   = instrValid && (st_reg.state == RUN_ST);
    assign ctrlWord = {st_reg.taskSwitchedFp, st_reg.nativeFpError,
                       st_reg.monitorCoprocessorFlag, st_reg.fpSoftwareTrap};

    // feed the decision logic from the live control word
    assign dif.fpSoftwareTrap         = st_reg.fpSoftwareTrap;
    assign dif.monitorCoprocessorFlag = st_reg.monitorCoprocessorFlag;
    assign dif.taskSwitchedFp         = st_reg.taskSwitchedFp;
    assign dif.fpInstr                = accept && instrIsFp;
    assign dif.fpSyncInstr            = accept && instrIsFpSync;
    assign dif.noFpHw                 = noFpHw;
    assign dif.noHelper               = noFpHw && !emulatorPresent;

    // next-state logic: dispatch, error routing, registers and events
    always_comb begin
        st_next          = st_reg;
        evSet            = '0;
        st_next.exec     = 1'b0;
        st_next.fault    = 1'b0;
        st_next.syncDone = 1'b0;
        st_next.fpErr    = 1'b0;
        st_next.extErr   = 1'b0;
        st_next.rdData   = '0;

        // instruction outcome
        case (dif.outcome)
            OUT_EXEC: begin
                st_next.exec = 1'b1;
            end
            OUT_FAULT: begin
                st_next.fault          = 1'b1;
                evSet[EV_UNAVAIL_BIT]  = 1'b1;
            end
            OUT_SYNC_DONE: begin
                st_next.syncDone = 1'b1;
            end
            OUT_HANG: begin
                st_next.state       = HUNG_ST;
                evSet[EV_HANG_BIT]  = 1'b1;
            end
            default: begin
                st_next.exec = 1'b0;
            end
        endcase

        // unmasked numeric error routing
        if (numericError) begin
            if (st_reg.nativeFpError) begin
                st_next.fpErr        = 1'b1;
                evSet[EV_NATIVE_BIT] = 1'b1;
            end else begin
                st_next.extErr       = 1'b1;
                evSet[EV_EXTERN_BIT] = 1'b1;
            end
        end

        // control word write, task-switch event wins over a clearing write
        if (regWrite && regAddr == CTRL_OFS) begin
            st_next.fpSoftwareTrap         = regWrData[CTRL_TRAP_BIT];
            st_next.monitorCoprocessorFlag = regWrData[CTRL_MONITOR_BIT];
            st_next.nativeFpError          = regWrData[CTRL_NATIVE_BIT];
            st_next.taskSwitchedFp         = regWrData[CTRL_TASKSW_BIT];
        end
        if (taskSwitchEvent) begin
            st_next.taskSwitchedFp = 1'b1;
        end

        // mask write
        if (regWrite && regAddr == MASK_OFS) begin
            st_next.mask = regWrData[EV_W-1:0];
        end

        // register read, one cycle latency; unmapped reads return zero
        if (regRead) begin
            case (regAddr)
                CTRL_OFS: begin
                    st_next.rdData[CTRL_W-1:0] = ctrlWord;
                end
                STATUS_OFS: begin
                    st_next.rdData[EV_W-1:0] = st_reg.status;
                end
                MASK_OFS: begin
                    st_next.rdData[EV_W-1:0] = st_reg.mask;
                end
                STATE_OFS: begin
                    st_next.rdData[STATE_HUNG_BIT] = (st_reg.state == HUNG_ST);
                    st_next.rdData[STATE_NOHW_BIT] = noFpHw;
                end
                default: begin
                    st_next.rdData = '0;
                end
            endcase
        end

        // sticky status: read clears, a new event in the same cycle survives
        if (regRead && regAddr == STATUS_OFS) begin
            st_next.status = evSet;
        end else begin
            st_next.status = st_reg.status | evSet;
        end

        st_next.hung = (st_next.state == HUNG_ST);
        st_next.irq  = |(st_next.status & st_next.mask);

        // synchronous reset clears every flag and output
        if (reset) begin
            st_next.state                  = RUN_ST;
            st_next.fpSoftwareTrap         = CTRL_RESET[CTRL_TRAP_BIT];
            st_next.monitorCoprocessorFlag = CTRL_RESET[CTRL_MONITOR_BIT];
            st_next.nativeFpError          = CTRL_RESET[CTRL_NATIVE_BIT];
            st_next.taskSwitchedFp         = CTRL_RESET[CTRL_TASKSW_BIT];
            st_next.status                 = STATUS_RESET;
            st_next.mask                   = MASK_RESET;
            st_next.rdData                 = '0;
            st_next.exec                   = 1'b0;
            st_next.fault                  = 1'b0;
            st_next.syncDone               = 1'b0;
            st_next.fpErr                  = 1'b0;
            st_next.extErr                 = 1'b0;
            st_next.hung                   = 1'b0;
            st_next.irq                    = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    // outputs straight from the state register
    assign regRdData           = st_reg.rdData;
    assign fpuExecute          = st_reg.exec;
    assign fpuUnavailableFault = st_reg.fault;
    assign syncComplete        = st_reg.syncDone;
    assign fpErrorFault        = st_reg.fpErr;
    assign extErrorRequest     = st_reg.extErr;
    assign coreHung            = st_reg.hung;
    assign irq                 = st_reg.irq;

    // checks on dispatch and control behaviour
    AST_RESET_CLEARS: assert property (@(posedge clk)
        reset |=> !st_reg.fpSoftwareTrap && !st_reg.monitorCoprocessorFlag
                  && !st_reg.nativeFpError && !coreHung)
        else $error("control flags not cleared by reset");

    AST_EXEC_WHEN_CLEAR: assert property (@(posedge clk) disable iff (reset)
        accept && instrIsFp && !instrIsFpSync && !st_reg.fpSoftwareTrap && !noFpHw
        |=> fpuExecute && !fpuUnavailableFault)
        else $error("fp instruction not executed with trap clear");

    AST_TRAP_FAULTS: assert property (@(posedge clk) disable iff (reset)
        accept && instrIsFp && !instrIsFpSync && st_reg.fpSoftwareTrap
        && !(noFpHw && !emulatorPresent)
        |=> fpuUnavailableFault && !fpuExecute)
        else $error("fp instruction did not fault with trap set");

    AST_SYNC_IGNORES: assert property (@(posedge clk) disable iff (reset)
        accept && instrIsFpSync && !st_reg.monitorCoprocessorFlag
        |=> syncComplete && !fpuUnavailableFault)
        else $error("sync instruction reacted to task-switched flag");

    AST_SYNC_FAULTS: assert property (@(posedge clk) disable iff (reset)
        accept && instrIsFpSync && st_reg.monitorCoprocessorFlag && st_reg.taskSwitchedFp
        |=> fpuUnavailableFault && !syncComplete && st_reg.status[EV_UNAVAIL_BIT])
        else $error("sync instruction did not fault");

    AST_NATIVE_ROUTE: assert property (@(posedge clk) disable iff (reset)
        numericError && st_reg.nativeFpError |=> fpErrorFault && !extErrorRequest)
        else $error("numeric error not raised internally");

    AST_EXTERN_ROUTE: assert property (@(posedge clk) disable iff (reset)
        numericError && !st_reg.nativeFpError |=> extErrorRequest && !fpErrorFault)
        else $error("numeric error not sent external");

    AST_HANG_HOLDS: assert property (@(posedge clk) disable iff (reset)
        accept && instrIsFp && !instrIsFpSync && st_reg.fpSoftwareTrap
        && noFpHw && !emulatorPresent
        |=> coreHung [*4])
        else $error("processor did not hang without any helper");

    AST_HUNG_SILENT: assert property (@(posedge clk) disable iff (reset)
        coreHung |=> !fpuExecute && !syncComplete && !fpuUnavailableFault)
        else $error("instruction dispatched while hung");

    AST_NO_HW_FAULTS: assert property (@(posedge clk) disable iff (reset)
        accept && instrIsFp && !instrIsFpSync && noFpHw && !st_reg.fpSoftwareTrap
        |=> fpuUnavailableFault && !fpuExecute)
        else $error("missing hardware did not fault");

    AST_CTRL_READBACK: assert property (@(posedge clk) disable iff (reset)
        regWrite && regAddr == CTRL_OFS ##1 regRead && regAddr == CTRL_OFS
        && !$past(taskSwitchEvent)
        |=> regRdData[CTRL_W-1:0] == $past(regWrData[CTRL_W-1:0], 2))
        else $error("control word did not read back");

    // a hang is left only through reset
    AST_HUNG_STAYS: assert property (@(posedge clk) disable iff (reset)
        coreHung |=> coreHung)
        else $error("hang released without reset");

    // at most one dispatch answer per instruction
    AST_ONE_ANSWER: assert property (@(posedge clk) disable iff (reset)
        $onehot0({fpuExecute, fpuUnavailableFault, syncComplete}))
        else $error("more than one dispatch answer");

    // an external error always leaves its sticky status bit behind
    AST_EXTERN_STATUS: assert property (@(posedge clk) disable iff (reset)
        numericError && !st_reg.nativeFpError |=> st_reg.status[EV_EXTERN_BIT])
        else $error("external error status not set");

    // an internal error always leaves its sticky status bit behind
    AST_NATIVE_STATUS: assert property (@(posedge clk) disable iff (reset)
        numericError && st_reg.nativeFpError |=> st_reg.status[EV_NATIVE_BIT])
        else $error("internal error status not set");

    // read data stand only in the cycle after a read
    AST_READ_IDLE: assert property (@(posedge clk) disable iff (reset)
        !regRead |=> regRdData == 32'h0)
        else $error("read data outside a read answer");

endmodule

// >>> src/fp_dispatch_pkg.sv
// shared constants and types for the floating-point dispatch control block
package fp_dispatch_pkg;

    // register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] MASK_OFS   = 4'h8;
    localparam logic [ADDR_W-1:0] STATE_OFS  = 4'hc;

    // system control word field positions
    localparam int CTRL_TRAP_BIT    = 0;
    localparam int CTRL_MONITOR_BIT = 1;
    localparam int CTRL_NATIVE_BIT  = 2;
    localparam int CTRL_TASKSW_BIT  = 3;
    localparam int CTRL_W           = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

    // event status and mask field positions
    localparam int EV_UNAVAIL_BIT = 0;
    localparam int EV_NATIVE_BIT  = 1;
    localparam int EV_EXTERN_BIT  = 2;
    localparam int EV_HANG_BIT    = 3;
    localparam int EV_W           = 4;
    localparam logic [EV_W-1:0] STATUS_RESET = 4'h0;
    localparam logic [EV_W-1:0] MASK_RESET   = 4'h0;

    // read-only state register field positions
    localparam int STATE_HUNG_BIT = 0;
    localparam int STATE_NOHW_BIT = 1;

    // outcome of one dispatched instruction
    typedef enum logic [2:0] {
        OUT_NONE,
        OUT_EXEC,
        OUT_FAULT,
        OUT_HANG,
        OUT_SYNC_DONE
    } outcome_e;

    // top-level run state
    typedef enum logic {
        RUN_ST,
        HUNG_ST
    } run_e;

endpackage

// >>> test/fp_dispatch_control_tb.sv
// self-checking bench for the floating-point dispatch control block
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module fp_dispatch_control_tb
    import fp_dispatch_pkg::*;
;
    logic              clk;
    logic              reset;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData;
    logic              regWrite;
    logic              regRead;
    logic [DATA_W-1:0] regRdData;
    logic              instrValid;
    logic              instrIsFp;
    logic              instrIsFpSync;
    logic              taskSwitchEvent;
    logic              numericError;
    logic              coprocPresent;
    logic              emulatorPresent;
    logic              fpuExecute;
    logic              fpuUnavailableFault;
    logic              syncComplete;
    logic              fpErrorFault;
    logic              extErrorRequest;
    logic              coreHung;
    logic              irq;
    int                fails;
    int                check_count;

    // no built-in hardware, so the coprocessor level alone decides presence
    fp_dispatch_control #(.FP_HW_PRESENT(1'b0)) u_fp_dispatch_control (
        .clk                 (clk),
        .reset               (reset),
        .regAddr             (regAddr),
        .regWrData           (regWrData),
        .regWrite            (regWrite),
        .regRead             (regRead),
        .regRdData           (regRdData),
        .instrValid          (instrValid),
        .instrIsFp           (instrIsFp),
        .instrIsFpSync       (instrIsFpSync),
        .taskSwitchEvent     (taskSwitchEvent),
        .numericError        (numericError),
        .coprocPresent       (coprocPresent),
        .emulatorPresent     (emulatorPresent),
        .fpuExecute          (fpuExecute),
        .fpuUnavailableFault (fpuUnavailableFault),
        .syncComplete        (syncComplete),
        .fpErrorFault        (fpErrorFault),
        .extErrorRequest     (extErrorRequest),
        .coreHung            (coreHung),
        .irq                 (irq)
    );

    // 50 MHz clock
    always #10 clk = ~clk;

    // prints the counts and the verdict, then ends the run
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", fails, check_count);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one-cycle register write
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clk);
        regWrite  <= 1'b0;
    endtask

    // one-cycle register read, data judged in the following cycle
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        `CHK(regRdData, e)
    endtask

    // write followed at once by a read, data judged in the cycle after the read
    task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         input logic [DATA_W-1:0] e);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clk);
        regWrite  <= 1'b0;
        regRead   <= 1'b1;
        @(posedge clk);
        regRead   <= 1'b0;
        #1;
        `CHK(regRdData, e)
    endtask

    // issue one instruction, expect {hung, execute, fault, sync done}
    task automatic issue(input logic fp, input logic sync, input logic [3:0] e);
        @(posedge clk);
        instrValid    <= 1'b1;
        instrIsFp     <= fp;
        instrIsFpSync <= sync;
        @(posedge clk);
        instrValid    <= 1'b0;
        #1;
        `CHK({coreHung, fpuExecute, fpuUnavailableFault, syncComplete}, e)
    endtask

    // numeric error pulse, expect {internal fault, external request}
    task automatic num_err(input logic [1:0] e);
        @(posedge clk);
        numericError <= 1'b1;
        @(posedge clk);
        numericError <= 1'b0;
        #1;
        `CHK({fpErrorFault, extErrorRequest}, e)
    endtask

    // reset values of every register and an unmapped read
    task automatic check_reset;
        rd(CTRL_OFS, 32'h0);
        rd(STATUS_OFS, 32'h0);
        rd(MASK_OFS, 32'h0);
        rd(STATE_OFS, 32'h0);
        rd(4'h2, 32'h0);
    endtask

    // control word read-back, read-only state, task-switch event
    task automatic check_regs;
        wr_rd(CTRL_OFS, 32'h7, 32'h7);
        wr(STATE_OFS, 32'hffff_ffff);
        rd(STATE_OFS, 32'h0);
        wr(CTRL_OFS, 32'h0);
        @(posedge clk);
        taskSwitchEvent <= 1'b1;
        @(posedge clk);
        taskSwitchEvent <= 1'b0;
        rd(CTRL_OFS, 32'h8);
    endtask

    // floating-point dispatch with trap clear then set
    task automatic check_fp;
        wr(CTRL_OFS, 32'h0);
        issue(1'b1, 1'b0, 4'b0100);
        issue(1'b1, 1'b0, 4'b0100);
        wr(CTRL_OFS, 32'h1);
        issue(1'b1, 1'b0, 4'b0010);
        issue(1'b0, 1'b0, 4'b0000);
    endtask

    // sync instruction against monitor and task-switched flags
    task automatic check_sync;
        wr(CTRL_OFS, 32'h8);
        issue(1'b0, 1'b1, 4'b0001);
        wr(CTRL_OFS, 32'ha);
        issue(1'b0, 1'b1, 4'b0010);
        issue(1'b1, 1'b1, 4'b0010);
        wr(CTRL_OFS, 32'h2);
        issue(1'b0, 1'b1, 4'b0001);
    endtask

    // numeric error routing, status, mask and interrupt
    task automatic check_errors;
        rd(STATUS_OFS, 32'h1);
        wr(MASK_OFS, 32'h4);
        wr(CTRL_OFS, 32'h4);
        num_err(2'b10);
        `CHK(irq, 1'b0)
        wr(CTRL_OFS, 32'h0);
        num_err(2'b01);
        `CHK(irq, 1'b1)
        rd(STATUS_OFS, 32'h6);
        `CHK(irq, 1'b0)
        rd(STATUS_OFS, 32'h0);
    endtask

    // no hardware: fault with trap clear or emulator present, hang with trap set and no emulator, reset recovers
    task automatic check_nohw;
        @(posedge clk);
        coprocPresent <= 1'b0;
        rd(STATE_OFS, 32'h2);
        wr(CTRL_OFS, 32'h0);
        issue(1'b1, 1'b0, 4'b0010);
        @(posedge clk);
        emulatorPresent <= 1'b1;
        wr(CTRL_OFS, 32'h5);
        issue(1'b1, 1'b0, 4'b0010);
        @(posedge clk);
        emulatorPresent <= 1'b0;
        issue(1'b1, 1'b0, 4'b1000);
        issue(1'b0, 1'b1, 4'b1000);
        rd(STATE_OFS, 32'h3);
        rd(STATUS_OFS, 32'h9);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset         <= 1'b0;
        coprocPresent <= 1'b1;
        #1;
        `CHK(coreHung, 1'b0)
        rd(CTRL_OFS, 32'h0);
    endtask

    // main sequence
    initial begin
        clk             = 1'b0;
        reset           = 1'b1;
        regAddr         = 4'h0;
        regWrData       = 32'h0;
        regWrite        = 1'b0;
        regRead         = 1'b0;
        instrValid      = 1'b0;
        instrIsFp       = 1'b0;
        instrIsFpSync   = 1'b0;
        taskSwitchEvent = 1'b0;
        numericError    = 1'b0;
        coprocPresent   = 1'b1;
        emulatorPresent = 1'b0;
        fails           = 0;
        check_count     = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        check_reset();
        check_regs();
        check_fp();
        check_sync();
        check_errors();
        check_nohw();
        finish_test();
    end

    // bound on the whole run
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test();
    end
endmodule
